/* verilog/aarr_cfg.svh */
`ifndef AARR_CFG_SVH
`define AARR_CFG_SVH

// register indices; byte address is four times the index
`define AARR_IDX_DIE_MAIN_HI 14'h05AE
`define AARR_IDX_DIE_MAIN_LO 14'h05AF
`define AARR_IDX_DIE_RED_HI 14'h05B0
`define AARR_IDX_DIE_RED_LO 14'h05B1
`define AARR_IDX_CELL_HI 14'h05B2
`define AARR_IDX_CELL_LO 14'h05B3
`define AARR_IDX_PIN_HI 14'h05B4
`define AARR_IDX_PIN_LO 14'h05B5
`define AARR_IDX_BAT_HI 14'h05B6
`define AARR_IDX_BAT_LO 14'h05B7
`define AARR_IDX_LOW_INTERNAL_REFERENCE_HI 14'h05B8
`define AARR_IDX_LOW_INTERNAL_REFERENCE_LO 14'h05B9
`define AARR_IDX_BG2_HI 14'h05BA
`define AARR_IDX_BG2_LO 14'h05BB
`define AARR_IDX_CTRL 14'h05BC
`define AARR_IDX_STATUS 14'h05BD
`define AARR_IDX_AON_HI 14'h05BE
`define AARR_IDX_AON_LO 14'h05BF
`define AARR_IDX_AVDD_HI 14'h05C0
`define AARR_IDX_AVDD_LO 14'h05C1

// reset values of every result pair
`define AARR_RST_HI 8'h80
`define AARR_RST_LO 8'h00

// control register fields
`define AARR_CELL_SEL_POS 0
`define AARR_PIN_SEL_POS 8
`define AARR_CTRL_RST 32'h00000000
`define AARR_CELL_SEL_SWEEP 5'h00

`define AARR_NUM_PAIRS 9

`endif

/* verilog/aarr_pkg.sv */
package aarr_pkg;

  typedef enum logic [2:0] {
    AARR_SRC_DIE_TEMP = 3'b000,
    AARR_SRC_CELL = 3'b001,
    AARR_SRC_PIN = 3'b010,
    AARR_SRC_BAT = 3'b011,
    AARR_SRC_LOW_INTERNAL_REFERENCE = 3'b100,
    AARR_SRC_BG2 = 3'b101,
    AARR_SRC_AON = 3'b110,
    AARR_SRC_AVDD = 3'b111
  } aarr_src_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } aarr_main_result_type;

  typedef struct packed {
    logic valid;
    aarr_src_type src;
    logic [4:0] chan;
    logic [15:0] data;
  } aarr_aux_result_type;

  typedef struct packed {
    logic [3:0] pin_sel;
    logic [4:0] cell_sel;
  } aarr_ctrl_type;

endpackage : aarr_pkg

/* verilog/aarr_pair.sv */
`timescale 1ns/1ns
`include "aarr_cfg.svh"
module aarr_pair (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // new conversion
  input wire logic upd_valid,
  input wire logic [15:0] upd_data,
  // read strobes from the bus slave
  input wire logic hi_rd,
  input wire logic lo_rd,
  // held value
  output logic [15:0] live_q,
  output logic [7:0] lo_q,
  output logic locked_q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      live_q <= {`AARR_RST_HI, `AARR_RST_LO};
    end else if (upd_valid) begin
      live_q <= upd_data;
    end
  end

  // a high read always wins the lock; low read releases it
  always_ff @(posedge clk) begin
    if (rst) begin
      locked_q <= 1'b0;
    end else if (hi_rd) begin
      locked_q <= 1'b1;
    end else if (lo_rd) begin
      locked_q <= 1'b0;
    end
  end

  // shown low byte; refreshed from the live value on release so
  // an update that arrived while frozen is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      lo_q <= `AARR_RST_LO;
    end else if (hi_rd) begin
      lo_q <= lo_q;
    end else if (upd_valid && (!locked_q || lo_rd)) begin
      lo_q <= upd_data[7:0];
    end else if (locked_q && lo_rd) begin
      lo_q <= live_q[7:0];
    end
  end

endmodule : aarr_pair

/* verilog/aarr_top.sv */
`timescale 1ns/1ns
`include "aarr_cfg.svh"
module aarr_top
  import aarr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter results
  input wire aarr_main_result_type main_res,
  input wire aarr_aux_result_type aux_res,
  // to the correction logic
  output logic [15:0] die_temp_correction,
  // selects, to the aux sequencer
  output aarr_ctrl_type ctrl_out
);

  localparam int NP = `AARR_NUM_PAIRS;

  localparam logic [NP-1:0][13:0] HI_IDX = {
    `AARR_IDX_AVDD_HI, `AARR_IDX_AON_HI, `AARR_IDX_BG2_HI,
    `AARR_IDX_LOW_INTERNAL_REFERENCE_HI, `AARR_IDX_BAT_HI, `AARR_IDX_PIN_HI,
    `AARR_IDX_CELL_HI, `AARR_IDX_DIE_RED_HI, `AARR_IDX_DIE_MAIN_HI
  };
  localparam logic [NP-1:0][13:0] LO_IDX = {
    `AARR_IDX_AVDD_LO, `AARR_IDX_AON_LO, `AARR_IDX_BG2_LO,
    `AARR_IDX_LOW_INTERNAL_REFERENCE_LO, `AARR_IDX_BAT_LO, `AARR_IDX_PIN_LO,
    `AARR_IDX_CELL_LO, `AARR_IDX_DIE_RED_LO, `AARR_IDX_DIE_MAIN_LO
  };

  logic [13:0] idx;
  logic aligned;
  logic setup_acc;
  logic done_acc;
  logic [NP-1:0] hit_hi;
  logic [NP-1:0] hit_lo;
  logic [NP-1:0] hi_rd;
  logic [NP-1:0] lo_rd;
  logic [NP-1:0] upd;
  logic [NP-1:0][15:0] upd_data;
  logic [NP-1:0][15:0] live;
  logic [NP-1:0][7:0] lo_q;
  logic [NP-1:0] locked;
  logic hit_ctrl;
  logic hit_status;
  logic cell_locked;
  logic [31:0] next_prdata;
  logic next_pslverr;
  aarr_ctrl_type ctrl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////
  // bus decode

  assign idx = paddr[15:2];
  assign aligned = (paddr[1:0] == 2'h0);
  // data and read side effects are settled on the same edge that raises pready
  assign setup_acc = psel && penable && !pready;
  assign done_acc = psel && penable && pready;
  assign hit_ctrl = aligned && (idx == `AARR_IDX_CTRL);
  assign hit_status = aligned && (idx == `AARR_IDX_STATUS);

  ////////////////////////////////////////////////////////////////////
  // result pairs

  assign cell_locked = (ctrl.cell_sel != `AARR_CELL_SEL_SWEEP);

  always_comb begin
    upd = '0;
    upd_data = '0;
    upd[0] = main_res.valid;
    upd_data[0] = main_res.data;
    for (int k = 1; k < NP; k++) begin
      upd_data[k] = aux_res.data;
    end
    if (aux_res.valid) begin
      case (aux_res.src)
        AARR_SRC_DIE_TEMP: upd[1] = 1'b1;
        AARR_SRC_CELL: begin
          upd[2] = cell_locked && (aux_res.chan == ctrl.cell_sel);
        end
        AARR_SRC_PIN: begin
          upd[3] = !aux_res.chan[4]
            && (aux_res.chan[3:0] == ctrl.pin_sel);
        end
        AARR_SRC_BAT: upd[4] = 1'b1;
        AARR_SRC_LOW_INTERNAL_REFERENCE: upd[5] = 1'b1;
        AARR_SRC_BG2: upd[6] = 1'b1;
        AARR_SRC_AON: upd[7] = 1'b1;
        AARR_SRC_AVDD: upd[8] = 1'b1;
        default: upd = upd;
      endcase
    end
  end

  // cell data arrives signed and is stored whole, sign in bit 15
  // of the word, so the high byte carries the sign

  for (genvar g = 0; g < NP; g++) begin : gen_pair
    assign hit_hi[g] = aligned && (idx == HI_IDX[g]);
    assign hit_lo[g] = aligned && (idx == LO_IDX[g]);
    assign hi_rd[g] = setup_acc && !pwrite && hit_hi[g];
    assign lo_rd[g] = setup_acc && !pwrite && hit_lo[g];

    aarr_pair u_pair (
      .clk(clk),
      .rst(rst),
      .upd_valid(upd[g]),
      .upd_data(upd_data[g]),
      .hi_rd(hi_rd[g]),
      .lo_rd(lo_rd[g]),
      .live_q(live[g]),
      .lo_q(lo_q[g]),
      .locked_q(locked[g])
    );

    a_low_frozen: assert property (
      $past(locked[g]) && locked[g] |-> lo_q[g] == $past(lo_q[g])
    ) else $error("low byte moved while frozen");

    a_lock_set: assert property (
      hi_rd[g] |=> locked[g] ##1 (locked[g] || $past(lo_rd[g]))
    ) else $error("high read did not freeze low byte");

    a_lock_release: assert property (
      lo_rd[g] && !hi_rd[g] |=> !locked[g]
    ) else $error("low read did not release freeze");

    a_hi_data: assert property (
      hi_rd[g] |=> prdata[7:0] == $past(live[g][15:8])
    ) else $error("high read did not return the live high byte");

    a_lo_data: assert property (
      lo_rd[g] |=> prdata[7:0] == $past(lo_q[g])
    ) else $error("low read did not return the held low byte");
  end

  ////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= aarr_ctrl_type'(`AARR_CTRL_RST);
    end else if (done_acc && pwrite && hit_ctrl) begin
      ctrl.cell_sel <= pwdata[`AARR_CELL_SEL_POS +: 5];
      ctrl.pin_sel <= pwdata[`AARR_PIN_SEL_POS +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_out <= aarr_ctrl_type'(`AARR_CTRL_RST);
    end else begin
      ctrl_out <= ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b1;
    if (hit_ctrl) begin
      next_prdata[`AARR_CELL_SEL_POS +: 5] = ctrl.cell_sel;
      next_prdata[`AARR_PIN_SEL_POS +: 4] = ctrl.pin_sel;
      next_pslverr = 1'b0;
    end else if (hit_status && !pwrite) begin
      next_prdata[NP-1:0] = locked;
      next_pslverr = 1'b0;
    end else if (!pwrite) begin
      for (int k = 0; k < NP; k++) begin
        if (hit_hi[k]) begin
          next_prdata[7:0] = live[k][15:8];
          next_pslverr = 1'b0;
        end
        if (hit_lo[k]) begin
          next_prdata[7:0] = lo_q[k];
          next_pslverr = 1'b0;
        end
      end
    end
  end

  // one wait state: pready pulses for a single cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_acc;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_acc) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_pslverr;
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // correction temperature

  always_ff @(posedge clk) begin
    if (rst) begin
      die_temp_correction <= {`AARR_RST_HI, `AARR_RST_LO};
    end else begin
      die_temp_correction <= live[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence s_access_wait;
    psel && penable && !pready;
  endsequence

  sequence s_main_temp;
    main_res.valid;
  endsequence

  sequence s_aux_src(aarr_src_type s);
    aux_res.valid && aux_res.src == s;
  endsequence

  // a cell result counts only while the select holds one channel
  sequence s_cell_hit;
    aux_res.valid && aux_res.src == AARR_SRC_CELL
      && ctrl.cell_sel != `AARR_CELL_SEL_SWEEP
      && aux_res.chan == ctrl.cell_sel;
  endsequence

  sequence s_pin_hit;
    aux_res.valid && aux_res.src == AARR_SRC_PIN
      && !aux_res.chan[4] && aux_res.chan[3:0] == ctrl.pin_sel;
  endsequence

  a_ready_timing: assert property (
    s_access_wait |=> pready ##1 !pready
  ) else $error("pready not a single pulse after one wait");

  a_ready_origin: assert property (
    pready |-> $past(psel && penable && !pready)
  ) else $error("pready without a waiting access");

  a_err_with_ready: assert property (
    pslverr |-> pready
  ) else $error("pslverr outside the answer cycle");

  a_status_flags: assert property (
    setup_acc && hit_status && !pwrite
      |=> prdata[NP-1:0] == $past(locked)
  ) else $error("status does not show the lock flags");

  a_ctrl_write: assert property (
    done_acc && pwrite && hit_ctrl
      |=> ctrl.cell_sel == $past(pwdata[`AARR_CELL_SEL_POS +: 5])
      && ctrl.pin_sel == $past(pwdata[`AARR_PIN_SEL_POS +: 4])
  ) else $error("control write did not land");

  a_ctrl_refused: assert property (
    done_acc && pwrite && !hit_ctrl |=> ctrl == $past(ctrl)
  ) else $error("control moved without a control write");

  a_ctrl_copy: assert property (
    ctrl_out == $past(ctrl)
  ) else $error("selects out differ from control register");

  a_main_fill: assert property (
    s_main_temp |=> live[0] == $past(main_res.data)
  ) else $error("main temperature pair not filled");

  a_main_only: assert property (
    !main_res.valid |=> live[0] == $past(live[0])
  ) else $error("main temperature pair moved without main result");

  a_red_fill: assert property (
    s_aux_src(AARR_SRC_DIE_TEMP) |=> live[1] == $past(aux_res.data)
  ) else $error("redundant temperature pair not filled");

  a_corr_track: assert property (
    s_main_temp ##2 1 |-> die_temp_correction == $past(main_res.data, 2)
  ) else $error("correction temperature not from main pair");

  a_cell_sign: assert property (
    upd[2] |=> live[2][15] == $past(aux_res.data[15])
  ) else $error("cell sign bit lost");

  a_cell_fill: assert property (
    s_cell_hit |=> live[2] == $past(aux_res.data)
  ) else $error("locked cell result not held");

  a_cell_gate: assert property (
    !cell_locked |=> live[2] == $past(live[2])
  ) else $error("cell pair updated while sweeping");

  a_pin_pick: assert property (
    s_pin_hit |=> live[3] == $past(aux_res.data)
  ) else $error("selected pin result not held");

  a_pin_other: assert property (
    !upd[3] |=> live[3] == $past(live[3])
  ) else $error("pin pair moved for unselected pin");

  a_bat_fill: assert property (
    s_aux_src(AARR_SRC_BAT) |=> live[4] == $past(aux_res.data)
  ) else $error("battery pin pair not filled");

  a_ref_fill: assert property (
    s_aux_src(AARR_SRC_LOW_INTERNAL_REFERENCE) |=> live[5] == $past(aux_res.data)
  ) else $error("low reference pair not filled");

  a_bg2_fill: assert property (
    s_aux_src(AARR_SRC_BG2) |=> live[6] == $past(aux_res.data)
  ) else $error("second bandgap pair not filled");

  a_aon_fill: assert property (
    s_aux_src(AARR_SRC_AON) |=> live[7] == $past(aux_res.data)
  ) else $error("always-on reference pair not filled");

  a_avdd_fill: assert property (
    s_aux_src(AARR_SRC_AVDD) |=> live[8] == $past(aux_res.data)
  ) else $error("analog supply pair not filled");

endmodule : aarr_top

/* tb/aarr_top_tb.sv */
`timescale 1ns/1ns
`include "aarr_cfg.svh"
module aarr_top_tb
  import aarr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  aarr_main_result_type main_res = '0;
  aarr_aux_result_type aux_res = '0;
  logic [15:0] die_temp_correction;
  aarr_ctrl_type ctrl_out;
  int error_cnt = 0;
  int comparisons = 0;
  // high-byte index of each pair, in status flag order
  logic [13:0] hi_idx [9] = '{14'h05AE, 14'h05B0, 14'h05B2, 14'h05B4,
    14'h05B6, 14'h05B8, 14'h05BA, 14'h05BE, 14'h05C0};
  aarr_src_type src_tab [5] = '{AARR_SRC_BAT, AARR_SRC_LOW_INTERNAL_REFERENCE, AARR_SRC_BG2,
    AARR_SRC_AON, AARR_SRC_AVDD};

  always #5 clk = ~clk;

  aarr_top aarr_top_inst (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .main_res(main_res),
    .aux_res(aux_res),
    .die_temp_correction(die_temp_correction),
    .ctrl_out(ctrl_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [13:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("ERROR pready expected 1 seen timeout");
      summarize();
    end
  endtask : apb

  task automatic rd(input logic [13:0] idx, input logic [31:0] ex,
    input logic ee, input string nm);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h00000000, d, e);
    chk(nm, ex, d);
    chk({nm, " pslverr"}, {31'h0, ee}, {31'h0, e});
  endtask : rd

  // high byte first, so each pair read also exercises the lock path
  task automatic pr(input logic [13:0] hi, input logic [15:0] ex,
    input string nm);
    rd(hi, {24'h0, ex[15:8]}, 1'b0, {nm, " high"});
    rd(hi + 14'h0001, {24'h0, ex[7:0]}, 1'b0, {nm, " low"});
  endtask : pr

  task automatic main_pulse(input logic [15:0] d);
    @(posedge clk);
    main_res <= {1'b1, d};
    @(posedge clk);
    main_res.valid <= 1'b0;
  endtask : main_pulse

  task automatic aux_pulse(input aarr_src_type s, input logic [4:0] ch,
    input logic [15:0] d);
    @(posedge clk);
    aux_res <= {1'b1, s, ch, d};
    @(posedge clk);
    aux_res.valid <= 1'b0;
  endtask : aux_pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic e;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk("correction", 32'h00008000, {16'h0, die_temp_correction});
    chk("ctrl_out", 32'h0, {23'h0, ctrl_out});
    for (int i = 0; i < 9; i++) begin
      pr(hi_idx[i], 16'h8000, "reset pair");
    end
    $display("test reset values done");

    // sweep mode must not fill the cell pair
    aux_pulse(AARR_SRC_CELL, 5'h00, 16'h7777);
    pr(hi_idx[2], 16'h8000, "cell sweep");
    apb(1'b1, `AARR_IDX_CTRL, 32'h00000503, d, e);
    // the selects reach ctrl_out one edge after the write lands
    rd(`AARR_IDX_CTRL, 32'h00000503, 1'b0, "ctrl");
    chk("ctrl_out", 32'h000000A3, {23'h0, ctrl_out});
    aux_pulse(AARR_SRC_CELL, 5'h03, 16'hFF9C);
    aux_pulse(AARR_SRC_CELL, 5'h04, 16'h0001);
    pr(hi_idx[2], 16'hFF9C, "cell");
    aux_pulse(AARR_SRC_PIN, 5'h05, 16'h2468);
    aux_pulse(AARR_SRC_PIN, 5'h06, 16'h1111);
    aux_pulse(AARR_SRC_PIN, 5'h15, 16'h1357);
    pr(hi_idx[3], 16'h2468, "pin");
    $display("test select fields done");

    main_pulse(16'h1234);
    aux_pulse(AARR_SRC_DIE_TEMP, 5'h00, 16'hABCD);
    pr(hi_idx[0], 16'h1234, "die main");
    pr(hi_idx[1], 16'hABCD, "die redundant");
    chk("correction", 32'h00001234, {16'h0, die_temp_correction});
    for (int i = 0; i < 5; i++) begin
      aux_pulse(src_tab[i], 5'h00, 16'(16'h1111 * (i + 1)));
    end
    for (int i = 0; i < 5; i++) begin
      pr(hi_idx[i + 4], 16'(16'h1111 * (i + 1)), "aux pair");
    end
    $display("test result sources done");

    // low byte stays frozen between a high read and its low read
    rd(hi_idx[0], 32'h00000012, 1'b0, "lock high");
    main_pulse(16'h5678);
    rd(hi_idx[0], 32'h00000056, 1'b0, "lock high new");
    rd(`AARR_IDX_STATUS, 32'h00000001, 1'b0, "status locked");
    rd(hi_idx[0] + 14'h0001, 32'h00000034, 1'b0, "frozen low");
    rd(hi_idx[0] + 14'h0001, 32'h00000078, 1'b0, "resync low");
    rd(`AARR_IDX_STATUS, 32'h00000000, 1'b0, "status free");
    chk("correction", 32'h00005678, {16'h0, die_temp_correction});
    $display("test low byte lock done");

    apb(1'b1, hi_idx[4], 32'h000000FF, d, e);
    chk("write result pslverr", 32'h1, {31'h0, e});
    pr(hi_idx[4], 16'h1111, "after write");
    rd(14'h05C2, 32'h00000000, 1'b1, "unmapped");
    $display("test refused access done");
    summarize();
  end
endmodule : aarr_top_tb
